// ==== hdl/emb_bus.sv ====
// Notes on behaviour
// RULE1: The write strobe is low in every external write cycle and high otherwise.
// RULE2: The read strobe is low in every external read cycle and high otherwise.
// RULE3: The low lane enable goes low in every cycle that touches the low data byte.
// RULE4: The high lane enable goes low in every cycle that touches the high data byte.
// RULE5: In DRAM cycles the two lane enables act as the column strobes of their bytes.
// RULE6: A buffered copy of the core clock leaves the chip and software can switch it off.
// RULE7: Generic cycles put the whole 20-bit byte address on the address pins.
// RULE8: DRAM cycles put the row and then the column on address lines 17 to 7.
// RULE9: The 16-bit data bus is driven by us on writes and by the far side on reads.
// RULE10: While the wait pin is high the strobe phase is stretched.
// RULE11: The select/row strobe starts disabled and works as chip select or row strobe.
// RULE12: The data bus is released except while write data is driven.
`timescale 1ns/1ps
`default_nettype none

module emb_bus (
  input  wire logic                          core_clk,
  input  wire logic                          reset_n,
  input  wire logic                          req_valid,
  input  wire logic                          req_write,
  input  wire logic                          req_dram,
  input  wire logic                          req_select,
  input  wire logic [emb_pkg::LANE_W-1:0]    req_lanes,
  input  wire logic [emb_pkg::ADDR_W-1:0]    req_addr,
  input  wire logic [emb_pkg::DATA_W-1:0]    req_wdata,
  input  wire logic                          srs_enable,
  input  wire logic                          srs_row_mode,
  input  wire logic                          clk_out_enable,
  input  wire logic                          bus_hold_or_width_sel,
  input  wire logic [emb_pkg::DATA_W-1:0]    data_i,
  output logic                               req_ready,
  output logic                               resp_done,
  output logic [emb_pkg::DATA_W-1:0]         resp_rdata,
  output logic                               boot_bus_16,
  output logic                               write_strobe_n,
  output logic                               read_strobe_n,
  output logic                               low_lane_enable_n,
  output logic                               high_lane_enable_n,
  output logic                               select_row_strobe_n,
  output wire logic                          bus_clock_out,
  output logic [emb_pkg::ADDR_W-1:0]         addr_out,
  output logic [emb_pkg::DATA_W-1:0]         data_o,
  output logic                               data_oe
);

  emb_pkg::emb_state_t state;
  emb_pkg::emb_state_t next_state;

  logic                            wr;
  logic                            dram;
  logic                            sel;
  logic [emb_pkg::LANE_W-1:0]      lanes;
  logic [emb_pkg::ADDR_W-1:0]      addr;
  logic [emb_pkg::CNT_W-1:0]       cnt;
  logic                            hold_s1;
  logic                            hold_s2;
  logic [emb_pkg::DATA_W-1:0]      data_s1;
  logic [emb_pkg::DATA_W-1:0]      data_s2;
  logic                            strap_done;
  logic [emb_pkg::LANE_W-1:0]      lane_n;

  // Pin inputs pass two flops; the hold chain is left free so it sees the strap in reset
  always_ff @(posedge core_clk) begin
    hold_s1 <= bus_hold_or_width_sel;
    hold_s2 <= hold_s1;
    data_s1 <= data_i;
    data_s2 <= data_s1;
  end

  // Bus width strap is caught in the first cycle after reset is released
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      strap_done  <= 1'b0;
      boot_bus_16 <= 1'b0;
    end else if (!strap_done) begin
      strap_done  <= 1'b1;
      boot_bus_16 <= hold_s2;
    end
  end

  wire start      = (state == emb_pkg::EMB_IDLE) && req_valid;
  wire n_wr       = start ? req_write  : wr;
  wire n_dram     = start ? req_dram   : dram;
  wire n_sel      = start ? req_select : sel;
  wire [emb_pkg::LANE_W-1:0] n_lanes = start ? req_lanes : lanes;
  wire [emb_pkg::ADDR_W-1:0] n_addr  = start ? req_addr  : addr;
  wire cnt_done   = (cnt >= emb_pkg::CNT_LAST);
  wire strobe_end = (state == emb_pkg::EMB_STROBE) && cnt_done && !hold_s2;

  always_comb begin
    next_state = state;
    case (state)
      emb_pkg::EMB_IDLE: begin
        if (req_valid) begin
          next_state = req_dram ? emb_pkg::EMB_ROW : emb_pkg::EMB_SETUP;
        end
      end
      emb_pkg::EMB_SETUP: begin
        next_state = emb_pkg::EMB_STROBE;
      end
      emb_pkg::EMB_ROW: begin
        next_state = emb_pkg::EMB_STROBE;
      end
      emb_pkg::EMB_STROBE: begin
        if (strobe_end) begin
          next_state = emb_pkg::EMB_END; // see RULE10
        end
      end
      emb_pkg::EMB_END: begin
        next_state = emb_pkg::EMB_IDLE;
      end
      default: begin
        next_state = emb_pkg::EMB_IDLE;
      end
    endcase
  end

  wire n_strobe = (next_state == emb_pkg::EMB_STROBE);
  wire n_row    = (next_state == emb_pkg::EMB_ROW);
  wire n_drive  = (next_state == emb_pkg::EMB_SETUP) || n_row || n_strobe;
  wire n_busy   = (next_state != emb_pkg::EMB_IDLE);

  wire next_write_strobe_n = !(n_strobe && n_wr);  // see RULE1
  wire next_read_strobe_n  = !(n_strobe && !n_wr); // see RULE2

  // One enable per byte lane; in DRAM cycles it falls only after the row phase
  for (genvar i = 0; i < emb_pkg::LANE_W; i++) begin : g_lane
    assign lane_n[i] = !(n_strobe && n_lanes[i]); // see RULE3 see RULE4 see RULE5
  end

  wire [emb_pkg::DRAM_LINES-1:0] row_bits =
    emb_pkg::DRAM_LINES'(n_addr[emb_pkg::ADDR_W-1:emb_pkg::ROW_LSB]);
  wire [emb_pkg::DRAM_LINES-1:0] col_bits =
    n_addr[emb_pkg::ROW_LSB-1:emb_pkg::COL_LSB];
  wire [emb_pkg::DRAM_LINES-1:0] line_bits = n_row ? row_bits : col_bits;
  wire [emb_pkg::ADDR_W-1:0] dram_word =
    {{emb_pkg::DRAM_PAD_W{1'b0}}, line_bits, {emb_pkg::DRAM_LSB{1'b0}}}; // see RULE8
  wire [emb_pkg::ADDR_W-1:0] next_addr_out =
    !n_busy ? addr_out : (n_dram ? dram_word : n_addr); // see RULE7

  wire srs_cs_on  = !n_dram && (next_state == emb_pkg::EMB_SETUP || n_strobe);
  wire srs_ras_on = n_dram && (n_row || n_strobe);
  wire next_select_row_strobe_n =
    !(srs_enable && n_sel && (srs_row_mode ? srs_ras_on : srs_cs_on)); // see RULE11

  wire next_data_oe = n_wr && n_drive; // see RULE12 see RULE9

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      state <= emb_pkg::EMB_IDLE;
      wr    <= 1'b0;
      dram  <= 1'b0;
      sel   <= 1'b0;
      lanes <= '0;
      addr  <= '0;
      cnt   <= emb_pkg::CNT_ZERO;
    end else begin
      state <= next_state;
      wr    <= n_wr;
      dram  <= n_dram;
      sel   <= n_sel;
      lanes <= n_lanes;
      addr  <= n_addr;
      cnt   <= (state == emb_pkg::EMB_STROBE) ? cnt + emb_pkg::CNT_ONE : emb_pkg::CNT_ZERO;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      req_ready           <= 1'b0;
      resp_done           <= 1'b0;
      resp_rdata          <= '0;
      write_strobe_n      <= 1'b1;
      read_strobe_n       <= 1'b1;
      low_lane_enable_n   <= 1'b1;
      high_lane_enable_n  <= 1'b1;
      select_row_strobe_n <= 1'b1;
      addr_out            <= '0;
      data_o              <= '0;
      data_oe             <= 1'b0;
    end else begin
      req_ready           <= !n_busy;
      resp_done           <= strobe_end;
      if (strobe_end && !wr) begin
        resp_rdata <= data_s2; // see RULE9
      end
      write_strobe_n      <= next_write_strobe_n;
      read_strobe_n       <= next_read_strobe_n;
      low_lane_enable_n   <= lane_n[emb_pkg::LANE_LO];
      high_lane_enable_n  <= lane_n[emb_pkg::LANE_HI];
      select_row_strobe_n <= next_select_row_strobe_n;
      addr_out            <= next_addr_out;
      if (start) begin
        data_o <= req_wdata;
      end
      data_oe             <= next_data_oe;
    end
  end

  emb_clk_gate u_clk_gate (
    .core_clk (core_clk),
    .reset_n  (reset_n),
    .enable   (clk_out_enable),
    .clk_out  (bus_clock_out)
  );

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  write_strobe_cycle_a: assert property ( // see RULE1
    !write_strobe_n |-> wr && state == emb_pkg::EMB_STROBE)
    else $error("write strobe outside a write strobe phase");
  read_strobe_cycle_a: assert property ( // see RULE2
    (state == emb_pkg::EMB_STROBE) && !wr |-> !read_strobe_n && write_strobe_n)
    else $error("read strobe wrong during read");
  low_lane_a: assert property ( // see RULE3
    (state == emb_pkg::EMB_STROBE) |-> (low_lane_enable_n == !lanes[emb_pkg::LANE_LO]))
    else $error("low lane enable does not follow the lanes");
  high_lane_a: assert property ( // see RULE4
    (state == emb_pkg::EMB_STROBE) |-> (high_lane_enable_n == !lanes[emb_pkg::LANE_HI]))
    else $error("high lane enable does not follow the lanes");
  cas_after_row_a: assert property ( // see RULE5
    (state == emb_pkg::EMB_ROW) |-> low_lane_enable_n && high_lane_enable_n ##1
    (low_lane_enable_n == !lanes[emb_pkg::LANE_LO]))
    else $error("column strobe not after row phase");
  generic_addr_a: assert property ( // see RULE7
    (state == emb_pkg::EMB_STROBE) && !dram |-> addr_out == addr)
    else $error("generic address not on the pins");
  dram_mux_a: assert property ( // see RULE8
    (state == emb_pkg::EMB_ROW) |->
    addr_out[emb_pkg::ROW_LSB+emb_pkg::DRAM_LSB-emb_pkg::COL_LSB-1:emb_pkg::DRAM_LSB]
      == emb_pkg::DRAM_LINES'(addr[emb_pkg::ADDR_W-1:emb_pkg::ROW_LSB]) ##1
    addr_out[emb_pkg::ROW_LSB+emb_pkg::DRAM_LSB-emb_pkg::COL_LSB-1:emb_pkg::DRAM_LSB]
      == addr[emb_pkg::ROW_LSB-1:emb_pkg::COL_LSB])
    else $error("row then column not on the DRAM lines");
  wait_stretch_a: assert property ( // see RULE10
    (state == emb_pkg::EMB_STROBE) && hold_s2 |=> state == emb_pkg::EMB_STROBE)
    else $error("strobe ended while wait held");
  srs_off_a: assert property ( // see RULE11
    !srs_enable |=> select_row_strobe_n)
    else $error("select strobe active while disabled");
  data_release_a: assert property ( // see RULE12
    data_oe |-> wr && state != emb_pkg::EMB_IDLE && state != emb_pkg::EMB_END)
    else $error("data bus driven outside a write");
  done_pulse_a: assert property ( // see RULE10
    strobe_end |=> resp_done ##1 !resp_done && req_ready)
    else $error("done pulse or ready wrong");

  write_seen_c: cover property (start && req_write && !req_dram ##[4:8] resp_done);
  read_seen_c:  cover property (start && !req_write && !req_dram ##[4:8] resp_done);
  dram_seen_c:  cover property (start && req_dram && srs_row_mode ##[4:8] resp_done);
  wait_seen_c:  cover property ((state == emb_pkg::EMB_STROBE) && cnt_done && hold_s2);

endmodule

`default_nettype wire

// ==== inc/emb_pkg.sv ====
package emb_pkg;

  localparam int ADDR_W     = 20;
  localparam int DATA_W     = 16;
  localparam int LANE_W     = 2;
  localparam int LANE_LO    = 0;
  localparam int LANE_HI    = 1;
  // DRAM sees only the address lines 17 down to 7
  localparam int DRAM_LINES = 11;
  localparam int DRAM_LSB   = 7;
  localparam int DRAM_PAD_W = ADDR_W - DRAM_LSB - DRAM_LINES;
  // Column is the word address bits 11..1, row the bits above
  localparam int COL_LSB    = 1;
  localparam int ROW_LSB    = COL_LSB + DRAM_LINES;
  localparam int ROW_W      = ADDR_W - ROW_LSB;

  localparam int CLK_PERIOD_NS  = 8;
  localparam int STROBE_MIN_NS  = 24;
  localparam int STROBE_MIN_CYC = (STROBE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W          = 3;
  localparam logic [CNT_W-1:0] CNT_ZERO = 3'h0;
  localparam logic [CNT_W-1:0] CNT_ONE  = 3'h1;
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(STROBE_MIN_CYC - 1);

  typedef enum logic [2:0] {
    EMB_IDLE,
    EMB_SETUP,
    EMB_ROW,
    EMB_STROBE,
    EMB_END
  } emb_state_t;

endpackage

// ==== hdl/emb_clk_gate.sv ====
`timescale 1ns/1ps
`default_nettype none

module emb_clk_gate (
  input  wire logic core_clk,
  input  wire logic reset_n,
  input  wire logic enable,
  output wire logic clk_out
);

  logic en_p;
  logic en_q;

  // Enable is taken on the rising edge so it never races inputs that move on the falling one
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      en_p <= 1'b0;
    end else begin
      en_p <= enable;
    end
  end

  // Gate enable moves only while the clock is low, so the gated copy never glitches
  always_ff @(negedge core_clk) begin
    en_q <= en_p;
  end

  assign clk_out = core_clk & en_q; // see RULE6

endmodule

`default_nettype wire

// ==== bench/emb_mem_model.sv ====
`timescale 1ns/1ps
`default_nettype none

module emb_mem_model (
  input  wire logic                       core_clk,
  input  wire logic                       reset_n,
  input  wire logic                       stall,
  input  wire logic                       strap,
  input  wire logic                       write_strobe_n,
  input  wire logic                       read_strobe_n,
  input  wire logic                       low_lane_enable_n,
  input  wire logic                       high_lane_enable_n,
  input  wire logic [emb_pkg::ADDR_W-1:0] addr_out,
  input  wire logic [emb_pkg::DATA_W-1:0] data_o,
  input  wire logic                       data_oe,
  output logic                            bus_hold_or_width_sel,
  output logic [emb_pkg::DATA_W-1:0]      data_i
);
  logic [emb_pkg::DATA_W-1:0] mem [logic [emb_pkg::ADDR_W-1:0]];
  logic [emb_pkg::DATA_W-1:0] last = 16'h0000;
  logic [emb_pkg::DATA_W-1:0] w;
  int                         held = 0;

  always @(posedge core_clk) begin
    if (!write_strobe_n && data_oe) begin
      w = mem.exists(addr_out) ? mem[addr_out] : 16'h0000;
      if (!low_lane_enable_n) w[7:0] = data_o[7:0];
      if (!high_lane_enable_n) w[15:8] = data_o[15:8];
      mem[addr_out] = w;
    end
    held <= (write_strobe_n && read_strobe_n) ? 0 : held + 1;
    last <= data_i;
  end

  // Released bus shows a toggling pattern, never a held value
  always @* begin
    if (data_oe) data_i = data_o;
    else if (!read_strobe_n && mem.exists(addr_out)) data_i = mem[addr_out];
    else data_i = ~last;
  end

  // Strap level in reset, wait request for four strobe cycles when stalling
  assign bus_hold_or_width_sel = !reset_n ? strap : (stall && held < 4);
endmodule

`default_nettype wire

// ==== bench/external_memory_bus_strobes_test.sv ====
`timescale 1ns/1ps
`default_nettype none

module external_memory_bus_strobes_test;
  typedef struct {
    logic rd; logic st; logic sel; logic [1:0] ln;
    logic [15:0] d; logic [19:0] ca; logic [19:0] ra;
  } emb_exp_t;

  logic        core_clk = 1'b0, reset_n = 1'b0, req_valid = 1'b0, req_write = 1'b0;
  logic        req_dram = 1'b0, srs_enable = 1'b1, srs_row_mode = 1'b0, clk_out_enable = 1'b1;
  logic        stall = 1'b0, hold, req_ready, resp_done, boot_bus_16, write_strobe_n;
  logic        read_strobe_n, low_lane_enable_n, high_lane_enable_n, select_row_strobe_n;
  logic        bus_clock_out, data_oe;
  logic        req_select = 1'b1;
  logic [1:0]  req_lanes = 2'h3;
  logic [19:0] req_addr = 20'h00000, addr_out, sa, ra;
  logic [15:0] req_wdata = 16'h0000, data_i, data_o, resp_rdata;
  logic [15:0] sh [logic [20:0]];
  logic [31:0] rnd = 32'h56f9;
  emb_exp_t    q[$];
  emb_exp_t    e;
  int          errors = 0, n_compared = 0, wc = 0, rc = 0, lo = 0, hi = 0, sc = 0, s, tgl = 0;

  always #4 core_clk = ~core_clk;
  always @(posedge bus_clock_out) tgl++;

  emb_bus DUT (.core_clk(core_clk), .reset_n(reset_n), .req_valid(req_valid),
    .req_write(req_write), .req_dram(req_dram), .req_select(req_select), .req_lanes(req_lanes),
    .req_addr(req_addr), .req_wdata(req_wdata), .srs_enable(srs_enable),
    .srs_row_mode(srs_row_mode), .clk_out_enable(clk_out_enable),
    .bus_hold_or_width_sel(hold), .data_i(data_i), .req_ready(req_ready),
    .resp_done(resp_done), .resp_rdata(resp_rdata), .boot_bus_16(boot_bus_16),
    .write_strobe_n(write_strobe_n), .read_strobe_n(read_strobe_n),
    .low_lane_enable_n(low_lane_enable_n), .high_lane_enable_n(high_lane_enable_n),
    .select_row_strobe_n(select_row_strobe_n), .bus_clock_out(bus_clock_out),
    .addr_out(addr_out), .data_o(data_o), .data_oe(data_oe));

  emb_mem_model mem (.core_clk(core_clk), .reset_n(reset_n), .stall(stall), .strap(1'b1),
    .write_strobe_n(write_strobe_n), .read_strobe_n(read_strobe_n),
    .low_lane_enable_n(low_lane_enable_n), .high_lane_enable_n(high_lane_enable_n),
    .addr_out(addr_out), .data_o(data_o), .data_oe(data_oe),
    .bus_hold_or_width_sel(hold), .data_i(data_i));

  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction

  task automatic chk(input logic ok, input string m);
    n_compared++;
    if (ok !== 1'b1) begin
      errors++;
      $display("CHECK FAILED t=%0t %s", $time, m);
    end
  endtask

  task automatic end_sim();
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // One bus cycle; the expectation is queued as the request is made
  task automatic cyc(input logic wr, input logic dr, input logic [1:0] ln, input logic st);
    emb_exp_t x;
    int n;
    n = 0;
    while (req_ready !== 1'b1 && n < 60) begin
      @(negedge core_clk);
      n++;
    end
    if (n >= 60) chk(1'b0, "ready never came");
    rnd = lfsr(rnd);
    {req_write, req_dram, req_lanes, stall, srs_row_mode} = {wr, dr, ln, st, dr};
    req_wdata = rnd[31:16];
    if (wr) begin
      if (!sh.exists({dr, req_addr})) sh[{dr, req_addr}] = 16'h0000;
      if (ln[0]) sh[{dr, req_addr}][7:0] = rnd[23:16];
      if (ln[1]) sh[{dr, req_addr}][15:8] = rnd[31:24];
    end
    x.rd = !wr; x.st = st; x.sel = srs_enable && req_select; x.ln = ln;
    x.d = sh[{dr, req_addr}];
    x.ca = dr ? {2'h0, req_addr[11:1], 7'h00} : req_addr;
    x.ra = dr ? {5'h00, req_addr[19:12], 7'h00} : req_addr;
    q.push_back(x);
    req_valid = 1'b1;
    @(negedge core_clk);
    req_valid = 1'b0;
  endtask

  always @(negedge core_clk) begin
    if (!write_strobe_n) wc++;
    if (!read_strobe_n) rc++;
    if (!low_lane_enable_n) lo++;
    if (!high_lane_enable_n) hi++;
    if (!select_row_strobe_n) sc++;
    if (!low_lane_enable_n || !high_lane_enable_n) sa = addr_out;
    if (!select_row_strobe_n && low_lane_enable_n && high_lane_enable_n) ra = addr_out;
    if (reset_n) chk(!(data_oe === 1'b1 && !read_strobe_n), "bus driven in read");
    if (resp_done === 1'b1) begin
      if (q.size() == 0) chk(1'b0, "done without request");
      else begin
        e = q.pop_front();
        s = e.rd ? rc : wc;
        chk((e.rd ? wc : rc) == 0, "wrong strobe active");
        chk(e.st ? s > 3 : s == 3, "strobe length");
        chk(lo == (e.ln[0] ? s : 0), "low lane enable");
        chk(hi == (e.ln[1] ? s : 0), "high lane enable");
        chk(sa === e.ca, "address in strobe phase");
        chk((sc > 0) == e.sel, "select strobe");
        if (e.sel) chk(ra === e.ra, "row or setup address");
        if (e.rd) chk(resp_rdata === e.d, "read data");
      end
      {wc, rc, lo, hi, sc} = '0;
    end
  end

  initial begin
    #(8 * 20000);
    chk(1'b0, "watchdog expired");
    end_sim();
  end

  initial begin
    repeat (5) @(negedge core_clk);
    reset_n = 1'b1;
    repeat (2) @(negedge core_clk);
    chk(boot_bus_16 === 1'b1, "bus width strap");
    for (int i = 0; i < 8; i++) begin
      rnd = lfsr(rnd);
      req_addr = {rnd[19:1], 1'b0};
      cyc(1'b1, i[0], 2'h3, i == 3);
      cyc(1'b0, i[0], 2'h3, 1'b0);
      cyc(1'b1, i[0], i[1] ? 2'h2 : 2'h1, 1'b0);
      cyc(1'b0, i[0], 2'h3, i == 5);
      $display("test cycles %0d done", i);
    end
    while (q.size() != 0) @(negedge core_clk);
    srs_enable = 1'b0;
    cyc(1'b1, 1'b0, 2'h3, 1'b0);
    cyc(1'b0, 1'b0, 2'h3, 1'b0);
    repeat (10) @(negedge core_clk);
    srs_enable = 1'b1;
    req_select = 1'b0;
    cyc(1'b0, 1'b0, 2'h3, 1'b0);
    while (q.size() != 0) @(negedge core_clk);
    req_select = 1'b1;
    $display("test select disabled done");
    clk_out_enable = 1'b0;
    repeat (3) @(negedge core_clk);
    tgl = 0;
    repeat (10) @(negedge core_clk);
    chk(tgl == 0, "clock out disabled");
    clk_out_enable = 1'b1;
    repeat (3) @(negedge core_clk);
    tgl = 0;
    repeat (10) @(negedge core_clk);
    chk(tgl >= 9, "clock out running");
    $display("test clock out done");
    chk(q.size() == 0, "requests left unanswered");
    end_sim();
  end
endmodule

`default_nettype wire
